// *** hw/rwlc_top.sv ***
// Reset qualification, wake control, event pin and indicator drive.
// Assumes rst_n_pin and power_good_in come from pins, other inputs same clock.
// Functional notes
// - Reset low with power good high: hardware reset, event, wake, indicator and irq outputs off.
// - Reset may assert or release at any time versus the clock.
// - Power good low: reset only floats bus pins, state untouched.
// - Power good high: reset clears logic, then starts configuration load.
// - Power good low plus pin enable or mode bit enters wake mode.
// - Event out when status and enable, or override with match or link.
// - Event output drives open drain, not tied to the clock.
// - Reset low with power good high enables tree test mode.
// - Last clock edge in reset samples indicator 1 into eeprom flag.
// - Indicators default link, receive, transmit, transmit; reprogrammable.
// - Indicators default active low open drain; active high is totem pole.
// - Wake out on frame match in wake mode or link change mode.
// - Wake out polarity, power gating, drive type from loaded bits.
// - Power on reset floats wake out until settings are established.
// - Wake mode indicator is high while in wake mode.
`timescale 1ns/1ps

module rwlc_top
(
    input  wire logic                        aclk,
    input  wire logic                        aresetn,
    input  wire logic                        clk_en,
    input  wire logic                        rst_n_pin,
    input  wire logic                        power_good_in,
    input  wire logic                        wake_frame_match,
    input  wire logic                        link_change_detected,
    input  wire logic                        indicator_1_in,
    input  wire rwlc_pkg::rwlc_net_s         net_status,
    input  wire logic                        cfg_load_done,
    output logic                             cfg_load_start,
    output logic                             bus_pins_float,
    output logic                             nand_tree_en,
    output logic                             event_out_n_o,
    output logic                             event_out_n_oe,
    output logic                             remote_wake_out_o,
    output logic                             remote_wake_out_oe,
    output logic                             wake_mode_indicator,
    output logic [rwlc_pkg::NUM_LED-1:0]     indicator_o,
    output logic [rwlc_pkg::NUM_LED-1:0]     indicator_oe,
    output logic                             irq,
    input  wire logic [rwlc_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                        s_axi_awvalid,
    output logic                             s_axi_awready,
    input  wire logic [rwlc_pkg::DATA_W-1:0] s_axi_wdata,
    input  wire logic [3:0]                  s_axi_wstrb,
    input  wire logic                        s_axi_wvalid,
    output logic                             s_axi_wready,
    output logic [1:0]                       s_axi_bresp,
    output logic                             s_axi_bvalid,
    input  wire logic                        s_axi_bready,
    input  wire logic [rwlc_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                        s_axi_arvalid,
    output logic                             s_axi_arready,
    output logic [rwlc_pkg::DATA_W-1:0]      s_axi_rdata,
    output logic [1:0]                       s_axi_rresp,
    output logic                             s_axi_rvalid,
    input  wire logic                        s_axi_rready
);

    function automatic logic known_addr(input logic [rwlc_pkg::ADDR_W-1:0] a);
        known_addr = (a == rwlc_pkg::OFS_CTRL) || (a == rwlc_pkg::OFS_STATUS)
                  || (a == rwlc_pkg::OFS_IRQ_STAT) || (a == rwlc_pkg::OFS_IRQ_MASK)
                  || (a == rwlc_pkg::OFS_LED_CFG);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [1:0] rst_sync_r;
    logic [1:0] pg_sync_r;
    logic       rst_lo;
    logic       pg_hi;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rst_sync_r <= 2'h3;
            pg_sync_r  <= 2'h0;
        end
        else if (clk_en)
        begin
            rst_sync_r <= {rst_sync_r[0], rst_n_pin};
            pg_sync_r  <= {pg_sync_r[0], power_good_in};
        end
    end

    assign rst_lo = !rst_sync_r[1];
    assign pg_hi  = pg_sync_r[1];

    ////////////////////////////////////////////////////////////////////////////
    // Reset sequencer
    rwlc_pkg::rwlc_state_e state_r;
    rwlc_pkg::rwlc_state_e state_nxt;
    logic                  hw_rst;
    logic                  eeprom_r;
    logic                  eeprom_nxt;

    assign hw_rst = rst_lo && pg_hi;

    always_comb
    begin
        state_nxt  = state_r;
        eeprom_nxt = eeprom_r;
        if (hw_rst)
            eeprom_nxt = indicator_1_in;
        case (state_r)
            rwlc_pkg::ST_IDLE: if (hw_rst) state_nxt = rwlc_pkg::ST_HRST;
            rwlc_pkg::ST_HRST: if (!hw_rst) state_nxt = rwlc_pkg::ST_LDCF;
            rwlc_pkg::ST_LDCF:
            begin
                if (hw_rst)
                    state_nxt = rwlc_pkg::ST_HRST;
                else if (cfg_load_done)
                    state_nxt = rwlc_pkg::ST_IDLE;
            end
            default: state_nxt = rwlc_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_r  <= rwlc_pkg::ST_IDLE;
            eeprom_r <= 1'b0;
        end
        else if (clk_en)
        begin
            state_r  <= state_nxt;
            eeprom_r <= eeprom_nxt;
        end
    end

    assign cfg_load_start = (state_r == rwlc_pkg::ST_LDCF);
    assign nand_tree_en   = hw_rst;
    assign bus_pins_float = rst_lo;

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    logic [rwlc_pkg::CTRL_W-1:0] ctrl_r, ctrl_nxt;
    logic [rwlc_pkg::IRQ_W-1:0]  ist_r, ist_nxt, imask_r, imask_nxt;
    logic [11:0]                 led_r, led_nxt;
    logic                        cfg_valid_r, cfg_valid_nxt;
    logic                        aw_r, aw_nxt, w_r, w_nxt, b_r, b_nxt, bok_r, bok_nxt;
    logic [rwlc_pkg::ADDR_W-1:0] awa_r, awa_nxt;
    logic [rwlc_pkg::DATA_W-1:0] wd_r, wd_nxt, rd_r, rd_nxt;
    logic                        rv_r, rv_nxt;
    logic [1:0]                  rr_r, rr_nxt;
    logic                        wake_mode;
    logic [rwlc_pkg::IRQ_W-1:0]  ev;
    logic [rwlc_pkg::DATA_W-1:0] status_word;
    logic                        do_wr;

    assign wake_mode = !pg_hi && (ctrl_r[rwlc_pkg::CTRL_PIN_EN]
                     || ctrl_r[rwlc_pkg::CTRL_MODE]);
    assign ev = {hw_rst, link_change_detected, wake_frame_match && wake_mode};
    assign status_word = {28'h0000000, state_r == rwlc_pkg::ST_LDCF, hw_rst,
                          wake_mode, eeprom_r};
    assign do_wr = aw_r && w_r && !b_r;

    always_comb
    begin
        ctrl_nxt      = ctrl_r;
        imask_nxt     = imask_r;
        led_nxt       = led_r;
        ist_nxt       = ist_r;
        cfg_valid_nxt = cfg_valid_r;
        aw_nxt = aw_r; w_nxt = w_r; b_nxt = b_r; bok_nxt = bok_r;
        awa_nxt = awa_r; wd_nxt = wd_r;
        rv_nxt = rv_r; rd_nxt = rd_r; rr_nxt = rr_r;
        if (s_axi_awvalid && !aw_r)
        begin
            aw_nxt  = 1'b1;
            awa_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_r)
        begin
            w_nxt  = 1'b1;
            wd_nxt = s_axi_wdata;
        end
        if (do_wr)
        begin
            b_nxt   = 1'b1;
            bok_nxt = known_addr(awa_r);
            case (awa_r)
                rwlc_pkg::OFS_CTRL:
                begin
                    ctrl_nxt      = wd_r[rwlc_pkg::CTRL_W-1:0];
                    cfg_valid_nxt = 1'b1;
                end
                rwlc_pkg::OFS_IRQ_STAT: ist_nxt = ist_r & ~wd_r[rwlc_pkg::IRQ_W-1:0];
                rwlc_pkg::OFS_IRQ_MASK: imask_nxt = wd_r[rwlc_pkg::IRQ_W-1:0];
                rwlc_pkg::OFS_LED_CFG: led_nxt = wd_r[11:0];
                default: ;
            endcase
        end
        ist_nxt = ist_nxt | ev;
        if (hw_rst)
        begin
            ctrl_nxt      = rwlc_pkg::CTRL_RST;
            led_nxt       = rwlc_pkg::LED_CFG_RST;
            cfg_valid_nxt = 1'b0;
        end
        if (b_r && s_axi_bready)
        begin
            b_nxt = 1'b0; aw_nxt = 1'b0; w_nxt = 1'b0;
        end
        if (s_axi_arvalid && !rv_r)
        begin
            rv_nxt = 1'b1;
            rr_nxt = known_addr(s_axi_araddr) ? rwlc_pkg::RESP_OKAY : rwlc_pkg::RESP_SLVERR;
            case (s_axi_araddr)
                rwlc_pkg::OFS_CTRL:     rd_nxt = {23'h000000, ctrl_r};
                rwlc_pkg::OFS_STATUS:   rd_nxt = status_word;
                rwlc_pkg::OFS_IRQ_STAT: rd_nxt = {29'h00000000, ist_r};
                rwlc_pkg::OFS_IRQ_MASK: rd_nxt = {29'h00000000, imask_r};
                rwlc_pkg::OFS_LED_CFG:  rd_nxt = {20'h00000, led_r};
                default:                rd_nxt = 32'h00000000;
            endcase
        end
        else if (rv_r && s_axi_rready)
            rv_nxt = 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl_r <= rwlc_pkg::CTRL_RST; imask_r <= '0; ist_r <= '0;
            led_r <= rwlc_pkg::LED_CFG_RST; cfg_valid_r <= 1'b0;
            aw_r <= 1'b0; w_r <= 1'b0; b_r <= 1'b0; bok_r <= 1'b0;
            awa_r <= '0; wd_r <= '0; rv_r <= 1'b0; rd_r <= '0; rr_r <= 2'h0;
        end
        else if (clk_en)
        begin
            ctrl_r <= ctrl_nxt; imask_r <= imask_nxt; ist_r <= ist_nxt;
            led_r <= led_nxt; cfg_valid_r <= cfg_valid_nxt;
            aw_r <= aw_nxt; w_r <= w_nxt; b_r <= b_nxt; bok_r <= bok_nxt;
            awa_r <= awa_nxt; wd_r <= wd_nxt; rv_r <= rv_nxt; rd_r <= rd_nxt; rr_r <= rr_nxt;
        end
    end

    assign s_axi_awready = !aw_r;
    assign s_axi_wready  = !w_r;
    assign s_axi_bvalid  = b_r;
    assign s_axi_bresp   = bok_r ? rwlc_pkg::RESP_OKAY : rwlc_pkg::RESP_SLVERR;
    assign s_axi_arready = !rv_r;
    assign s_axi_rvalid  = rv_r;
    assign s_axi_rdata   = rd_r;
    assign s_axi_rresp   = rr_r;
    assign irq           = |(ist_r & imask_r) && !hw_rst;

    ////////////////////////////////////////////////////////////////////////////
    // Event, wake and indicator outputs
    logic evt_act;
    logic wake_act;
    logic wpol;

    // Event path is combinational from its inputs
    assign evt_act = (ctrl_r[rwlc_pkg::CTRL_EVT_STAT] && ctrl_r[rwlc_pkg::CTRL_EVT_EN])
                   || (ctrl_r[rwlc_pkg::CTRL_OVR]
                   && (wake_frame_match || link_change_detected));
    assign event_out_n_o  = 1'b0;
    assign event_out_n_oe = evt_act && !hw_rst;

    assign wake_act = (wake_mode && wake_frame_match)
                    || (ctrl_r[rwlc_pkg::CTRL_LCD_MODE] && link_change_detected);
    assign wpol = ctrl_r[rwlc_pkg::CTRL_WPOL];

    always_comb
    begin
        remote_wake_out_o  = wpol ? wake_act : !wake_act;
        remote_wake_out_oe = cfg_valid_r && !hw_rst;
        if (ctrl_r[rwlc_pkg::CTRL_WGATE] && !pg_hi)
            remote_wake_out_oe = 1'b0;
        else if (!ctrl_r[rwlc_pkg::CTRL_WDRV] && (wake_act == wpol))
            remote_wake_out_oe = 1'b0;
    end

    assign wake_mode_indicator = wake_mode;

    genvar gi;
    generate
        for (gi = 0; gi < rwlc_pkg::NUM_LED; gi++)
        begin : g_led
            logic [1:0] sel;
            logic       hi;
            logic       on;
            assign sel = led_r[gi*rwlc_pkg::LED_FLD_W +: rwlc_pkg::LED_SEL_W];
            assign hi  = led_r[gi*rwlc_pkg::LED_FLD_W + rwlc_pkg::LED_SEL_W];
            assign on  = (sel == rwlc_pkg::SEL_LINK) ? net_status.link_up :
                         (sel == rwlc_pkg::SEL_RX)   ? net_status.rx_act :
                         (sel == rwlc_pkg::SEL_COL)  ? net_status.col_act :
                                                       net_status.tx_act;
            assign indicator_o[gi]  = hi && on && !hw_rst;
            assign indicator_oe[gi] = !hw_rst && (hi || on);
        end
    endgenerate

endmodule

// *** hw/rwlc_pkg.sv ***
// Package for the reset, wake and indicator control block.
// Assumes a single clock domain at 50 MHz and an AXI4-Lite register bus.
package rwlc_pkg;

    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 32;
    localparam int unsigned NUM_LED = 4;

    // Register byte addresses
    localparam logic [ADDR_W-1:0] OFS_CTRL     = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h0c;
    localparam logic [ADDR_W-1:0] OFS_LED_CFG  = 8'h10;

    // Control register fields
    localparam int unsigned CTRL_PIN_EN   = 0;
    localparam int unsigned CTRL_MODE     = 1;
    localparam int unsigned CTRL_EVT_STAT = 2;
    localparam int unsigned CTRL_EVT_EN   = 3;
    localparam int unsigned CTRL_OVR      = 4;
    localparam int unsigned CTRL_LCD_MODE = 5;
    localparam int unsigned CTRL_WPOL     = 6;
    localparam int unsigned CTRL_WGATE    = 7;
    localparam int unsigned CTRL_WDRV     = 8;
    localparam int unsigned CTRL_W        = 9;
    localparam logic [CTRL_W-1:0] CTRL_RST = 9'h000;

    // Status fields
    localparam int unsigned ST_EEPROM = 0;
    localparam int unsigned ST_WAKE   = 1;
    localparam int unsigned ST_NAND   = 2;
    localparam int unsigned ST_LOAD   = 3;

    // Interrupt bits
    localparam int unsigned IRQ_W      = 3;
    localparam int unsigned IRQ_FRAME  = 0;
    localparam int unsigned IRQ_LINK   = 1;
    localparam int unsigned IRQ_HWRST  = 2;

    // Led config: per led 2 bits select, 1 bit polarity (1 = active high)
    localparam int unsigned LED_SEL_W = 2;
    localparam int unsigned LED_FLD_W = 3;
    localparam logic [1:0] SEL_LINK = 2'h0;
    localparam logic [1:0] SEL_RX   = 2'h1;
    localparam logic [1:0] SEL_COL  = 2'h2;
    localparam logic [1:0] SEL_TX   = 2'h3;
    localparam logic [11:0] LED_CFG_RST = 12'h6c8;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic link_up;
        logic rx_act;
        logic col_act;
        logic tx_act;
    } rwlc_net_s;

    typedef struct packed {
        logic out;
        logic oe;
    } rwlc_pin_s;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_HRST = 3'b010,
        ST_LDCF = 3'b100
    } rwlc_state_e;

endpackage

// *** tb/rwlc_top_assertions.sv ***
// Checker for the reset, wake and indicator block.
// Sees only top ports; bound from the bench top.
`timescale 1ns/1ps
module rwlc_top_assertions
(
    input wire logic                        aclk,
    input wire logic                        aresetn,
    input wire logic                        clk_en,
    input wire logic                        rst_n_pin,
    input wire logic                        power_good_in,
    input wire logic                        cfg_load_start,
    input wire logic                        cfg_load_done,
    input wire logic                        bus_pins_float,
    input wire logic                        nand_tree_en,
    input wire logic                        event_out_n_o,
    input wire logic [rwlc_pkg::NUM_LED-1:0] indicator_o,
    input wire logic [rwlc_pkg::NUM_LED-1:0] indicator_oe,
    input wire logic                        remote_wake_out_oe,
    input wire logic [rwlc_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic                        s_axi_awvalid,
    input wire logic                        s_axi_awready,
    input wire logic                        s_axi_arvalid,
    input wire logic                        s_axi_arready,
    input wire logic                        s_axi_rvalid
);
    logic [1:0] age_r;
    logic       seen_r;
    wire        ok = (age_r == 2'h3) && clk_en;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Cycles since reset, and first control write seen
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            age_r  <= 2'h0;
            seen_r <= 1'b0;
        end
        else
        begin
            if (age_r != 2'h3)
                age_r <= age_r + 2'h1;
            if (s_axi_awvalid && s_axi_awready && s_axi_awaddr == rwlc_pkg::OFS_CTRL)
                seen_r <= 1'b1;
        end
    end

    chk_tree_enable: assert property (ok |-> nand_tree_en ==
        (!$past(rst_n_pin, 2) && $past(power_good_in, 2))) else $error("tree enable wrong");
    chk_bus_float: assert property (ok |-> bus_pins_float == !$past(rst_n_pin, 2))
        else $error("bus float wrong");
    chk_reset_outs: assert property (nand_tree_en && $past(nand_tree_en) |->
        indicator_oe == '0 && !cfg_load_start) else $error("output live in reset");
    chk_event_drain: assert property (event_out_n_o == 1'b0)
        else $error("event pin driven high");
    chk_led_drive: assert property ((indicator_o & ~indicator_oe) == '0)
        else $error("led high level undriven");
    chk_load_stop: assert property (cfg_load_start && cfg_load_done |=> !cfg_load_start)
        else $error("load did not end");
    chk_load_begin: assert property ($fell(nand_tree_en) && power_good_in |->
        ##[0:3] cfg_load_start) else $error("load did not start");
    chk_wake_float: assert property (!seen_r |-> !remote_wake_out_oe)
        else $error("wake out driven early");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
endmodule

// *** tb/rwlc_loader_model.sv ***
// Configuration loader partner: ends a load after a latency.
// Assumes the block's clock and bus reset.
`timescale 1ns/1ps
module rwlc_loader_model
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic slow,
    input wire logic cfg_load_start,
    output logic     cfg_load_done
);
    logic [4:0] cnt_r;

    // One done pulse per load, quick or slow
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            cnt_r         <= 5'h00;
            cfg_load_done <= 1'b0;
        end
        else
        begin
            cfg_load_done <= 1'b0;
            if (cfg_load_start && !cfg_load_done)
            begin
                cnt_r <= cnt_r + 5'h01;
                if (cnt_r == (slow ? 5'h14 : 5'h03))
                    cfg_load_done <= 1'b1;
            end
            else
                cnt_r <= 5'h00;
        end
    end
endmodule

// *** tb/tb_rwlc_top.sv ***
// Self-checking bench for the reset, wake and indicator block.
// Assumes the checker and loader model files compile first.
`timescale 1ns/1ps
module tb_rwlc_top;
    logic aclk, aresetn, rst_n_pin, power_good_in, wake_frame_match, link_change_detected;
    logic indicator_1_in, cfg_load_done, cfg_load_start, bus_pins_float, nand_tree_en;
    logic event_out_n_o, event_out_n_oe, remote_wake_out_o, remote_wake_out_oe;
    logic wake_mode_indicator, irq, slow;
    logic [3:0] indicator_o, indicator_oe, s_axi_wstrb;
    rwlc_pkg::rwlc_net_s net_status;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int error_cnt = 0;
    int comparisons = 0;
    int tcnt = 0;

    rwlc_top dut (.aclk, .aresetn, .clk_en(1'b1), .rst_n_pin, .power_good_in,
        .wake_frame_match, .link_change_detected, .indicator_1_in, .net_status,
        .cfg_load_done, .cfg_load_start, .bus_pins_float, .nand_tree_en, .event_out_n_o,
        .event_out_n_oe, .remote_wake_out_o, .remote_wake_out_oe, .wake_mode_indicator,
        .indicator_o, .indicator_oe, .irq, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    rwlc_loader_model ldr (.aclk, .aresetn, .slow, .cfg_load_start, .cfg_load_done);

    initial
    begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    task automatic close_out();
        $display("Counts: %0d compares, %0d mismatches", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    always @(posedge aclk)
    begin
        tcnt <= tcnt + 1;
        if (tcnt == 20000)
        begin
            error_cnt++;
            close_out();
        end
    end

    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic cyc(int n);
        repeat (n) @(posedge aclk);
    endtask

    task automatic wr(logic [7:0] a, logic [31:0] d, output logic [1:0] r);
        bit aw_d, w_d;
        aw_d = 0;
        w_d = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(aw_d && w_d))
        begin
            @(posedge aclk);
            if (!aw_d && s_axi_awready === 1'b1)
            begin
                aw_d = 1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_d && s_axi_wready === 1'b1)
            begin
                w_d = 1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
    endtask

    task automatic rd(logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask

    // Expected {o, oe} of the indicators for a config and net state
    function automatic logic [7:0] led_exp(logic [11:0] c, logic [3:0] n);
        logic [3:0] o, oe;
        logic on;
        for (int k = 0; k < 4; k++)
        begin
            on = n[3 - c[3*k +: 2]];
            o[k] = c[3*k+2] & on;
            oe[k] = c[3*k+2] | on;
        end
        return {o, oe};
    endfunction

    initial
    begin
        logic [31:0] d;
        logic [1:0] r;
        logic [11:0] cfg;
        logic [3:0] ns;
        logic v, e;
        {aresetn, wake_frame_match, link_change_detected, indicator_1_in, slow} = '0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_awaddr, s_axi_araddr} = '0;
        {rst_n_pin, power_good_in, s_axi_bready, s_axi_rready} = 4'hf;
        net_status = '0;
        s_axi_wdata = '0;
        s_axi_wstrb = 4'hf;
        void'($urandom(32'h9d7b));
        cyc(12);
        aresetn <= 1'b1;
        cyc(4);
        rd(rwlc_pkg::OFS_LED_CFG, d, r);
        check("led cfg rst", d, {20'h0, rwlc_pkg::LED_CFG_RST});
        cfg = rwlc_pkg::LED_CFG_RST;
        for (int i = 0; i < 10; i++)
        begin
            if (i > 0)
            begin
                cfg = 12'($urandom);
                wr(rwlc_pkg::OFS_LED_CFG, {20'h0, cfg}, r);
            end
            ns = 4'($urandom);
            net_status <= ns;
            cyc(2);
            check("leds", {indicator_o, indicator_oe}, led_exp(cfg, ns));
        end
        rd(8'h40, d, r);
        check("bad rd data", d, 32'h0);
        check("bad rd resp", r, rwlc_pkg::RESP_SLVERR);
        wr(8'h40, 32'h0, r);
        check("bad wr", r, rwlc_pkg::RESP_SLVERR);
        $display("Test leds done");
        for (int b = 0; b < 2; b++)
        begin
            v = b[0];
            slow <= b[0];
            wr(rwlc_pkg::OFS_CTRL, 32'h1c, r);
            rst_n_pin <= 1'b0;
            indicator_1_in <= !v;
            cyc(4);
            check("tree en", nand_tree_en, 1);
            check("leds off", indicator_oe, 0);
            check("event off", {event_out_n_oe, irq}, 0);
            cyc(30);
            indicator_1_in <= v;
            cyc(2);
            rst_n_pin <= 1'b1;
            cyc(6);
            indicator_1_in <= !v;
            for (int i = 0; i < 100 && cfg_load_start !== 1'b0; i++)
                cyc(1);
            rd(rwlc_pkg::OFS_STATUS, d, r);
            check("eeprom flag", d[rwlc_pkg::ST_EEPROM], v);
            rd(rwlc_pkg::OFS_CTRL, d, r);
            check("ctrl cleared", d, 0);
        end
        $display("Test hard reset done");
        wr(rwlc_pkg::OFS_CTRL, 32'h1, r);
        check("wake mode pg", wake_mode_indicator, 0);
        power_good_in <= 1'b0;
        cyc(4);
        check("wake mode", wake_mode_indicator, 1);
        rst_n_pin <= 1'b0;
        cyc(4);
        check("float", {bus_pins_float, nand_tree_en}, 2'h2);
        rst_n_pin <= 1'b1;
        cyc(4);
        rd(rwlc_pkg::OFS_CTRL, d, r);
        check("ctrl kept", d, 1);
        wr(rwlc_pkg::OFS_CTRL, 32'h2, r);
        check("mode bit", wake_mode_indicator, 1);
        wr(rwlc_pkg::OFS_CTRL, 32'h0, r);
        check("mode off", wake_mode_indicator, 0);
        power_good_in <= 1'b1;
        cyc(4);
        $display("Test power low done");
        for (int i = 0; i < 32; i++)
        begin
            wr(rwlc_pkg::OFS_CTRL, {27'h0, i[2:0], 2'h0}, r);
            wake_frame_match <= i[3];
            link_change_detected <= i[4];
            cyc(2);
            e = (i[0] & i[1]) | (i[2] & (i[3] | i[4]));
            check("event", event_out_n_oe, e);
        end
        wake_frame_match <= 1'b0;
        link_change_detected <= 1'b0;
        wr(rwlc_pkg::OFS_IRQ_STAT, 32'h7, r);
        wr(rwlc_pkg::OFS_IRQ_MASK, 32'h0, r);
        link_change_detected <= 1'b1;
        cyc(1);
        link_change_detected <= 1'b0;
        cyc(2);
        rd(rwlc_pkg::OFS_IRQ_STAT, d, r);
        check("irq stat", {d[rwlc_pkg::IRQ_LINK], irq}, 2'h2);
        wr(rwlc_pkg::OFS_IRQ_MASK, 32'h2, r);
        cyc(1);
        check("irq on", irq, 1);
        wr(rwlc_pkg::OFS_IRQ_STAT, 32'h2, r);
        cyc(1);
        check("irq off", irq, 0);
        $display("Test event done");
        for (int i = 0; i < 8; i++)
        begin
            wr(rwlc_pkg::OFS_CTRL, 32'h20 | (i[0] << 6) | (i[2] << 8), r);
            link_change_detected <= i[1];
            cyc(2);
            v = i[1] ^ !i[0];
            check("wake", {remote_wake_out_o, remote_wake_out_oe}, {v, i[2] | !v});
            link_change_detected <= 1'b0;
        end
        wr(rwlc_pkg::OFS_CTRL, 32'h141, r);
        power_good_in <= 1'b0;
        wake_frame_match <= 1'b1;
        cyc(4);
        check("wake frame", {remote_wake_out_o, remote_wake_out_oe}, 2'h3);
        wake_frame_match <= 1'b0;
        wr(rwlc_pkg::OFS_CTRL, 32'h1a0, r);
        cyc(2);
        check("wake gate", remote_wake_out_oe, 0);
        power_good_in <= 1'b1;
        cyc(4);
        $display("Test wake done");
        close_out();
    end
endmodule

bind rwlc_top rwlc_top_assertions chk (.aclk, .aresetn, .clk_en, .rst_n_pin, .power_good_in,
    .cfg_load_start, .cfg_load_done, .bus_pins_float, .nand_tree_en, .event_out_n_o,
    .indicator_o, .indicator_oe, .remote_wake_out_oe, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);
